// *** hw/etp_pwm.sv ***
`timescale 1ns/100ps
`include "etp_defines.svh"
// Notes on behaviour
// - Period at maximum makes full-cycle active output impossible.
// - Trigger after channel match: clear, reassert output, keep counting.
// - Trigger before channel match: no channel interrupt, output stays.
// - Trigger after period interrupt: clear counter, keep counting up.
// - Trigger before period match: no period interrupt, clear, assert output.
// - Channel interrupt raised when counter reaches channel buffer value, except on its step from the period to one past it.
module etp_pwm
    import etp_pkg::*;
#(
    parameter int PRESCALE = `ETP_PRESCALE_DEF
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic trigger_pin,
    input wire logic [15:0] period_compare_register,
    input wire logic [15:0] channel_duty_compare_register,
    output logic channel_pulse_output,
    output logic channel_compare_interrupt,
    output logic period_compare_interrupt,
    output logic [15:0] count_value
);
    // ---------------------------------------------------------
    // State
    // ---------------------------------------------------------
    typedef struct packed
    {
        etp_state_t state;
        logic [2:0] trig_sync;
        logic trig_prev;
        logic trig_pend;
        logic [15:0] cnt;
        logic [15:0] period_compare_buffer;
        logic [15:0] channel_duty_compare_buffer;
        logic pulse;
        logic per_wait;
        logic ch_irq;
        logic per_irq;
    } etp_core_t;

    etp_core_t r;
    etp_core_t next_r;
    logic tick;
    logic trig_edge;

    // ---------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------
    // Next count value; wraps from the top value to zero as the
    // free-running counter does before its first trigger
    function automatic logic [15:0] etp_next_count(input logic [15:0] c);
        etp_next_count = c + `ETP_CNT_ONE;
    endfunction

    // A zero duty is matched at the restart count itself
    function automatic logic etp_is_zero(input logic [15:0] v);
        etp_is_zero = (v == `ETP_CNT_ZERO);
    endfunction

    // ---------------------------------------------------------
    // Count clock
    // ---------------------------------------------------------
    // Divider only runs in the run state, so the first count edge
    // after enable is a whole count period away
    etp_prescaler #(
        .DIV(PRESCALE)
    ) u_div (
        .clk(clk),
        .reset_n(reset_n),
        .run(r.state == ETP_RUN),
        .tick(tick)
    );

    // ---------------------------------------------------------
    // Trigger edge
    // ---------------------------------------------------------
    // Stable rising edge: second and third stages agree on high.
    // A pulse shorter than about two clocks may be lost.
    assign trig_edge = r.trig_sync[1] & r.trig_sync[2] & ~r.trig_prev;

    // ---------------------------------------------------------
    // Counter, compare and output logic
    // ---------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.ch_irq = 1'b0;
        next_r.per_irq = 1'b0;
        next_r.trig_sync = {r.trig_sync[1:0], trigger_pin};
        if (r.trig_sync[1] == r.trig_sync[2])
        begin
            next_r.trig_prev = r.trig_sync[2];
        end
        case (r.state)
            ETP_IDLE:
            begin
                next_r.pulse = 1'b0;
                next_r.trig_pend = 1'b0;
                next_r.per_wait = 1'b0;
                next_r.cnt = `ETP_CNT_MAX;
                next_r.period_compare_buffer = period_compare_register;
                next_r.channel_duty_compare_buffer =
                    channel_duty_compare_register;
                if (enable)
                begin
                    next_r.state = ETP_RUN;
                end
            end
            ETP_RUN:
            begin
                // Trigger is held until the next count edge so it
                // lands on the count clock like the compares do
                if (trig_edge)
                begin
                    next_r.trig_pend = 1'b1;
                end
                if (!enable)
                begin
                    // Idle values show one cycle after enable drops; a
                    // trigger caught in that cycle is dropped with them
                    next_r.state = ETP_IDLE;
                    next_r.cnt = `ETP_CNT_MAX;
                    next_r.pulse = 1'b0;
                    next_r.per_wait = 1'b0;
                    next_r.trig_pend = 1'b0;
                end
                else if (tick)
                begin
                    if (r.trig_pend || trig_edge)
                    begin
                        // Trigger wins over both compares, so a match due
                        // at this count raises nothing
                        next_r.trig_pend = 1'b0;
                        next_r.cnt = `ETP_CNT_ZERO;
                        next_r.per_wait = 1'b0;
                        // Reload buffers at restart
                        next_r.period_compare_buffer =
                            period_compare_register;
                        next_r.channel_duty_compare_buffer =
                            channel_duty_compare_register;
                        // Restart asserts the output
                        next_r.pulse = 1'b1;
                        if (etp_is_zero(channel_duty_compare_register))
                        begin
                            // A zero duty ends the pulse at the restart
                            // count; a period at the top value forces
                            // this, so no full-cycle output is possible
                            next_r.pulse = 1'b0;
                            next_r.ch_irq = 1'b1;
                        end
                    end
                    else if (r.per_wait)
                    begin
                        // Period closed: counter parks one past the
                        // period until a trigger, so a late trigger
                        // stretches the cycle
                        next_r.per_wait = 1'b1;
                    end
                    else if (r.cnt == r.period_compare_buffer)
                    begin
                        // Period interrupt on the count after the match,
                        // then park. The channel compare is skipped here,
                        // so a duty of period plus one never ends the pulse
                        next_r.cnt = etp_next_count(r.cnt);
                        next_r.per_irq = 1'b1;
                        next_r.per_wait = 1'b1;
                    end
                    else
                    begin
                        next_r.cnt = etp_next_count(r.cnt);
                        // Channel match: interrupt in the same cycle as
                        // the equality, not one count later
                        if (etp_next_count(r.cnt) ==
                            r.channel_duty_compare_buffer)
                        begin
                            next_r.ch_irq = 1'b1;
                            next_r.pulse = 1'b0;
                        end
                    end
                end
            end
            default:
            begin
                next_r.state = ETP_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------
    // State register
    // ---------------------------------------------------------
    // Reset values match the idle state, so no edge or interrupt
    // shows when reset lifts
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r <= '0;
            r.state <= ETP_IDLE;
            r.cnt <= `ETP_CNT_MAX;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ---------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------
    // Straight from flip-flops, so the far side sees no glitches
    assign channel_pulse_output = r.pulse;
    assign channel_compare_interrupt = r.ch_irq;
    assign period_compare_interrupt = r.per_irq;
    assign count_value = r.cnt;
endmodule // etp_pwm

// *** include/etp_defines.svh ***
`ifndef ETP_DEFINES_SVH
`define ETP_DEFINES_SVH
// Counter values
`define ETP_CNT_ZERO 16'h0000
`define ETP_CNT_MAX 16'hffff
`define ETP_CNT_ONE 16'h0001
// Default prescale: count enable every N operating clocks
`define ETP_PRESCALE_DEF 8
`endif

// *** include/etp_pkg.sv ***
package etp_pkg;
    typedef enum logic [0:0] {ETP_IDLE, ETP_RUN} etp_state_t;
endpackage

// *** hw/etp_prescaler.sv ***
`timescale 1ns/100ps
`include "etp_defines.svh"
// -------------------------------------------------------------
// Count clock divider: one-cycle enable every DIV clocks
// -------------------------------------------------------------
module etp_prescaler
    import etp_pkg::*;
#(
    parameter int DIV = `ETP_PRESCALE_DEF
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    output logic tick
);
    typedef struct packed
    {
        logic [15:0] cnt;
        logic tick;
    } etp_div_t;

    etp_div_t r;
    etp_div_t next_r;

    // Divider restarts when stopped so the first tick is a full period
    always_comb
    begin
        next_r = r;
        next_r.tick = 1'b0;
        if (!run)
        begin
            next_r.cnt = `ETP_CNT_ZERO;
        end
        else if (r.cnt == 16'(DIV - 1))
        begin
            next_r.cnt = `ETP_CNT_ZERO;
            next_r.tick = 1'b1;
        end
        else
        begin
            next_r.cnt = r.cnt + `ETP_CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign tick = r.tick;
endmodule // etp_prescaler

// *** dv/etp_pwm_props.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Pulse and interrupt timing checks
// ----------------------------------------
module etp_pwm_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic [15:0] period_compare_register,
    input wire logic [15:0] channel_duty_compare_register,
    input wire logic channel_pulse_output,
    input wire logic channel_compare_interrupt,
    input wire logic period_compare_interrupt,
    input wire logic [15:0] count_value
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Short aliases keep all but three properties on one line each
    wire ci = channel_compare_interrupt;
    wire pi = period_compare_interrupt;
    wire po = channel_pulse_output;
    wire [15:0] cv = count_value;
    wire [15:0] dr = channel_duty_compare_register;
    a_ch_once: assert property (ci |=> !ci)
        else $error("channel irq longer than one cycle");
    a_per_once: assert property (pi |=> !pi)
        else $error("period irq longer than one cycle");
    a_ch_count: assert property (ci |-> cv == dr)
        else $error("channel irq off its match count");
    a_ch_low: assert property (ci |-> !po)
        else $error("output still active at channel irq");
    a_per_park: assert property (pi |->
        cv == period_compare_register + 16'h0001)
        else $error("period irq off its count");
    a_fall_irq: assert property ($fell(po) && $past(enable) && enable
        |-> ci)
        else $error("output fell without channel irq");
    a_restart_on: assert property (enable && $changed(cv) &&
        cv == 16'h0000 && $past(cv) != 16'hffff && dr != 16'h0000
        |-> po)
        else $error("restart left output inactive");
    a_idle_state: assert property (!enable |=> cv == 16'hffff && !po)
        else $error("idle state wrong");
    // Main scenarios reached
    cover property (ci);
    cover property (pi);
    cover property ($rose(po));
endmodule // etp_pwm_props

bind etp_pwm etp_pwm_props u_etp_pwm_props (.*);

// *** dv/etp_trig_src.sv ***
`timescale 1ns/100ps
// Trigger source: one long pulse per request, long enough to pass the
// three-flop synchroniser; requests must be spaced beyond the hold
module etp_trig_src (
    input wire logic clk,
    input wire logic fire,
    output logic trigger_pin
);
    int hold = 0;
    // Pulse width counter
    always @(posedge clk)
    begin
        if (fire)
            hold <= 6;
        else if (hold > 0)
            hold <= hold - 1;
    end
    assign trigger_pin = hold != 0;
endmodule // etp_trig_src

// *** dv/etp_pwm_tb.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Bench for the triggered pulse generator
// ----------------------------------------
module etp_pwm_tb;
    logic clk = 0, reset_n = 0, enable = 0, fire = 0;
    logic [15:0] per = 16'h0014, duty = 16'h0005;
    wire trig, po, ci, pi;
    wire [15:0] cv;
    int err_count = 0, samples_checked = 0, n_ci = 0, n_pi = 0, n0, p0;
    always #5 clk = ~clk;
    // Interrupt tallies, so suppressed events show up as missing counts
    always @(posedge clk)
    begin
        n_ci <= n_ci + (ci === 1'b1);
        n_pi <= n_pi + (pi === 1'b1);
    end
    etp_trig_src u_etp_trig_src (.clk(clk), .fire(fire), .trigger_pin(trig));
    // Prescale of one keeps every count tick on a clock edge
    etp_pwm #(.PRESCALE(1)) u_etp_pwm (.clk(clk), .reset_n(reset_n),
        .enable(enable), .trigger_pin(trig), .period_compare_register(per),
        .channel_duty_compare_register(duty), .channel_pulse_output(po),
        .channel_compare_interrupt(ci), .period_compare_interrupt(pi),
        .count_value(cv));
    task check(input string name, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task kick;
        @(posedge clk) fire <= 1;
        @(posedge clk) fire <= 0;
    endtask
    // Registers change only in idle, where the buffers reload
    task setup(input logic [15:0] p, d);
        @(posedge clk) enable <= 0;
        per <= p;
        duty <= d;
        step(2);
        check("idle count", cv, 16'hffff);
        @(posedge clk) enable <= 1;
        n0 = n_ci;
        p0 = n_pi;
    endtask
    task t_basic;
        setup(16'h0014, 16'h0005);
        kick;
        for (int i = 0; i < 60 && ci !== 1'b1; i++) step(1);
        check("match count", cv, 16'h0005);
        check("output at match", po, 16'h0000);
        for (int i = 0; i < 60 && pi !== 1'b1; i++) step(1);
        check("park count", cv, 16'h0015);
        step(3);
        check("still parked", cv, 16'h0015);
        kick;
        for (int i = 0; i < 20 && po !== 1'b1; i++) step(1);
        check("restart output", po, 16'h0001);
    endtask
    task t_full;
        setup(16'h0014, 16'h0015);
        kick;
        step(40);
        check("full output", po, 16'h0001);
        check("no channel irq", 16'(n_ci - n0), 16'h0000);
    endtask
    task t_max;
        setup(16'hffff, 16'h0000);
        kick;
        step(30);
        check("max period output", po, 16'h0000);
    endtask
    // Restarts every eleven cycles, each after the first landing on the count where a
    // channel or period match would otherwise fall
    task t_repeat(input logic [15:0] p, d, ch_exp, po_exp);
        setup(p, d);
        repeat (6)
        begin
            kick;
            step(9);
        end
        check("channel irqs", 16'(n_ci - n0), ch_exp);
        check("period irqs", 16'(n_pi - p0), 16'h0000);
        check("output", po, po_exp);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        reset_n <= 1;
        t_basic;
        t_full;
        t_max;
        t_repeat(16'h0014, 16'h000b, 16'h0000, 16'h0001);
        t_repeat(16'h000a, 16'h0003, 16'h0006, 16'h0000);
        tally_and_finish;
    end
    // Watchdog well past the few hundred cycles the tests need
    initial
    begin
        #200000;
        err_count++;
        tally_and_finish;
    end
endmodule // etp_pwm_tb
